//--- bwcfg_pkg.sv
// package of offsets, field layouts, reset values and carriers for the bridge window registers
package bwcfg_pkg;

	localparam int BWCFG_AW = 8;
	localparam int BWCFG_DW = 32;

	// byte offsets in configuration space
	localparam logic [7:0] OFS_PF_LOW = 8'h24;
	localparam logic [7:0] OFS_PF_BASE_HI = 8'h28;
	localparam logic [7:0] OFS_PF_LIMIT_HI = 8'h2c;
	localparam logic [7:0] OFS_IO_HI = 8'h30;
	localparam logic [7:0] OFS_CAP = 8'h34;
	localparam logic [7:0] OFS_IRQ = 8'h3c;

	// field positions inside the prefetchable low dword
	localparam int PF_BASE_CAP_LSB = 0;
	localparam int PF_BASE_LSB = 4;
	localparam int PF_LIMIT_CAP_LSB = 16;
	localparam int PF_LIMIT_LSB = 20;
	localparam int PF_FIELD_W = 12;
	localparam int PF_CAP_W = 4;
	localparam int PF_LOW_BITS = 20;

	// field positions in the i/o upper and interrupt dwords
	localparam int IO_BASE_LSB = 0;
	localparam int IO_LIMIT_LSB = 16;
	localparam int IO_HI_W = 16;
	localparam int IRQ_LINE_LSB = 0;
	localparam int IRQ_PIN_LSB = 8;

	// constant and reset values
	localparam logic [3:0] PF_ADDR_CAP_64 = 4'h1;
	localparam logic [7:0] CAP_PTR_VAL = 8'hdc;
	localparam logic [7:0] IRQ_PIN_NONE = 8'h00;
	localparam logic [7:0] IRQ_LINE_RST = 8'h00;
	localparam logic [11:0] PF_FIELD_RST = 12'h000;
	localparam logic [31:0] HI32_RST = 32'h0000_0000;
	localparam logic [15:0] IO_HI_RST = 16'h0000;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	localparam logic [19:0] PF_BOTTOM_FILL = 20'h0_0000;
	localparam logic [19:0] PF_TOP_FILL = 20'hf_ffff;

	// a forwarding window, bottom and top inclusive
	typedef struct packed {
		logic [63:0] bottom;
		logic [63:0] top;
	} bwcfg_win64_s;

	// one register bus request as seen by the slave
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} bwcfg_req_s;

endpackage : bwcfg_pkg

//--- bwcfg_win_cmp.sv
// inclusive address window comparator
`timescale 1ns/1ps
module bwcfg_win_cmp #(
	parameter int W = 64
) (
	input wire logic [W-1:0] addr,
	input wire logic [W-1:0] bottom,
	input wire logic [W-1:0] top,
	output logic hit
);

	// unsigned compare; an inverted window (top below bottom) never hits
	assign hit = (addr >= bottom) && (addr <= top);

endmodule : bwcfg_win_cmp

//--- bwcfg_regs.sv
// forwarding-window configuration registers with avalon-mm slave and window decode
`timescale 1ns/1ps

//Contract
//- both prefetchable halves report a read-only 4-bit addressing field of 0001, meaning 64-bit capable.
//- bits 15:4 of the prefetchable dword hold a writable base for address bits 31:20, low 20 bits taken as zero.
//- bits 31:20 of that dword hold a writable limit for address bits 31:20, low 20 bits taken as all ones.
//- memory transactions are forwarded according to the prefetchable base and limit window.
//- a fully writable 32-bit register gives bits 63:32 of the window bottom and resets to zero.
//- a fully writable 32-bit register gives bits 63:32 of the window top and resets to zero.
//- a writable 16-bit field gives bits 31:16 of the i/o window bottom and resets to zero.
//- a writable 16-bit field gives bits 31:16 of the i/o window top and resets to zero.
//- the capability pointer reads as the constant DCh.
//- an 8-bit interrupt line value is stored as written, firmware being expected to write FFh.
//- bits 15:8 of the interrupt dword read as a constant saying no interrupt pin exists.
module bwcfg_regs
	import bwcfg_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [BWCFG_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [BWCFG_DW-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [BWCFG_DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic mem_addr_valid,
	input wire logic [63:0] mem_addr,
	input wire logic io_addr_valid,
	input wire logic [31:0] io_addr,
	output logic mem_fwd_valid,
	output logic mem_fwd_hit,
	output logic io_fwd_valid,
	output logic io_fwd_upper_hit,
	output logic [7:0] irq_line
);

	bwcfg_req_s req;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [11:0] pf_base_q;
	logic [11:0] pf_limit_q;
	logic [31:0] pf_base_hi_q;
	logic [31:0] pf_limit_hi_q;
	logic [15:0] io_base_hi_q;
	logic [15:0] io_limit_hi_q;
	logic [7:0] irq_line_q;
	logic mem_vld_q;
	logic mem_hit_q;
	logic io_vld_q;
	logic io_hit_q;

	assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata, be: avs_byteenable};

	// bus handshake: wait is held high on idle, dropped for one cycle per request
	wire req_any = req.rd | req.wr;
	wire req_done = req_any & ~wait_q;
	wire wr_done = req_done & req.wr;
	wire [5:0] widx = req.addr[7:2];

	wire sel_pf_low = (widx == OFS_PF_LOW[7:2]);
	wire sel_pf_bhi = (widx == OFS_PF_BASE_HI[7:2]);
	wire sel_pf_lhi = (widx == OFS_PF_LIMIT_HI[7:2]);
	wire sel_io_hi = (widx == OFS_IO_HI[7:2]);
	wire sel_cap = (widx == OFS_CAP[7:2]);
	wire sel_irq = (widx == OFS_IRQ[7:2]);

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// current contents of each mapped dword as software sees it
	wire [31:0] pf_low_word = {pf_limit_q, PF_ADDR_CAP_64, pf_base_q, PF_ADDR_CAP_64};
	wire [31:0] io_word = {io_limit_hi_q, io_base_hi_q};
	wire [31:0] cap_word = {24'h00_0000, CAP_PTR_VAL};
	wire [31:0] irq_word = {16'h0000, IRQ_PIN_NONE, irq_line_q};

	wire [31:0] pf_low_new = be_merge(pf_low_word, req.wdata, req.be);
	wire [31:0] pf_bhi_new = be_merge(pf_base_hi_q, req.wdata, req.be);
	wire [31:0] pf_lhi_new = be_merge(pf_limit_hi_q, req.wdata, req.be);
	wire [31:0] io_new = be_merge(io_word, req.wdata, req.be);
	wire [31:0] irq_new = be_merge(irq_word, req.wdata, req.be);

	// unmapped offsets read as zero and ignore writes
	wire [31:0] rd_mux = sel_pf_low ? pf_low_word :
		sel_pf_bhi ? pf_base_hi_q :
		sel_pf_lhi ? pf_limit_hi_q :
		sel_io_hi ? io_word :
		sel_cap ? cap_word :
		sel_irq ? irq_word : RD_UNMAPPED;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 1'b1;
			rdata_q <= RD_UNMAPPED;
		end else begin
			wait_q <= ~(req_any & wait_q);
			if (req.rd & wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// writes land on the edge where the master sees wait low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pf_base_q <= PF_FIELD_RST;
			pf_limit_q <= PF_FIELD_RST;
		end else if (wr_done && sel_pf_low) begin
			pf_base_q <= pf_low_new[PF_BASE_LSB +: PF_FIELD_W];
			pf_limit_q <= pf_low_new[PF_LIMIT_LSB +: PF_FIELD_W];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pf_base_hi_q <= HI32_RST;
			pf_limit_hi_q <= HI32_RST;
		end else begin
			if (wr_done && sel_pf_bhi) begin
				pf_base_hi_q <= pf_bhi_new;
			end
			if (wr_done && sel_pf_lhi) begin
				pf_limit_hi_q <= pf_lhi_new;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			io_base_hi_q <= IO_HI_RST;
			io_limit_hi_q <= IO_HI_RST;
		end else if (wr_done && sel_io_hi) begin
			io_base_hi_q <= io_new[IO_BASE_LSB +: IO_HI_W];
			io_limit_hi_q <= io_new[IO_LIMIT_LSB +: IO_HI_W];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_line_q <= IRQ_LINE_RST;
		end else if (wr_done && sel_irq) begin
			irq_line_q <= irq_new[IRQ_LINE_LSB +: 8];
		end
	end

	// full 64-bit window; the low 20 bits are implied, not stored
	bwcfg_win64_s pf_win;
	assign pf_win.bottom = {pf_base_hi_q, pf_base_q, PF_BOTTOM_FILL};
	assign pf_win.top = {pf_limit_hi_q, pf_limit_q, PF_TOP_FILL};

	logic mem_hit;
	logic io_hit;

	bwcfg_win_cmp #(
		.W(64)
	) u_pf_cmp (
		.addr(mem_addr),
		.bottom(pf_win.bottom),
		.top(pf_win.top),
		.hit(mem_hit)
	);

	// only the upper half of the i/o window lives here; the low half is decoded elsewhere
	bwcfg_win_cmp #(
		.W(16)
	) u_io_cmp (
		.addr(io_addr[31:16]),
		.bottom(io_base_hi_q),
		.top(io_limit_hi_q),
		.hit(io_hit)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_vld_q <= 1'b0;
			mem_hit_q <= 1'b0;
			io_vld_q <= 1'b0;
			io_hit_q <= 1'b0;
		end else begin
			mem_vld_q <= mem_addr_valid;
			mem_hit_q <= mem_addr_valid & mem_hit;
			io_vld_q <= io_addr_valid;
			io_hit_q <= io_addr_valid & io_hit;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign mem_fwd_valid = mem_vld_q;
	assign mem_fwd_hit = mem_hit_q;
	assign io_fwd_valid = io_vld_q;
	assign io_fwd_upper_hit = io_hit_q;
	assign irq_line = irq_line_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence rd_done_at(logic [7:0] ofs);
		req.rd && !wait_q && (req.addr[7:2] == ofs[7:2]);
	endsequence

	sequence wr_full_at(logic [7:0] ofs);
		req.wr && !wait_q && (req.addr[7:2] == ofs[7:2]) && (req.be == 4'hf);
	endsequence

	pf_cap_field_a: assert property (rd_done_at(OFS_PF_LOW) |->
		avs_readdata[3:0] == 4'h1 && avs_readdata[19:16] == 4'h1)
		else $error("prefetch addressing field not 0001");

	pf_base_wr_a: assert property (wr_full_at(OFS_PF_LOW) |=>
		pf_base_q == $past(req.wdata[15:4]) && pf_win.bottom[19:0] == 20'h0_0000)
		else $error("prefetch base not written");

	pf_limit_wr_a: assert property (wr_full_at(OFS_PF_LOW) |=>
		pf_limit_q == $past(req.wdata[31:20]) && pf_win.top[19:0] == 20'hf_ffff)
		else $error("prefetch limit not written");

	mem_fwd_hit_a: assert property (mem_addr_valid |=>
		mem_fwd_valid && mem_fwd_hit == ($past(mem_addr) >= $past(pf_win.bottom) &&
		$past(mem_addr) <= $past(pf_win.top)))
		else $error("forward decision wrong");

	base_hi_wr_a: assert property (wr_full_at(OFS_PF_BASE_HI) |=>
		pf_base_hi_q == $past(req.wdata) && pf_win.bottom[63:32] == $past(req.wdata))
		else $error("base upper not written");

	limit_hi_wr_a: assert property (wr_full_at(OFS_PF_LIMIT_HI) |=>
		pf_limit_hi_q == $past(req.wdata))
		else $error("limit upper not written");

	io_hi_wr_a: assert property (wr_full_at(OFS_IO_HI) |=>
		io_base_hi_q == $past(req.wdata[15:0]) && io_limit_hi_q == $past(req.wdata[31:16]))
		else $error("io upper fields not written");

	cap_ptr_rd_a: assert property (rd_done_at(OFS_CAP) |-> avs_readdata == 32'h0000_00dc)
		else $error("capability pointer not dc");

	irq_line_wr_a: assert property (wr_full_at(OFS_IRQ) |=> ##1 irq_line == $past(req.wdata[7:0], 2))
		else $error("interrupt line not stored");

	irq_pin_rd_a: assert property (rd_done_at(OFS_IRQ) |-> avs_readdata[15:8] == 8'h00)
		else $error("interrupt pin field not zero");

	wait_drop_a: assert property (req_any && wait_q |=> !wait_q ##1 wait_q)
		else $error("waitrequest sequence broken");

	mem_edge_hit_a: assert property (mem_addr_valid && mem_addr == pf_win.top &&
		pf_win.bottom <= pf_win.top |=> mem_fwd_hit)
		else $error("window top not inclusive");

	// readback of the stored upper halves, prefetchable low fields and interrupt line
	base_hi_rd_a: assert property (rd_done_at(OFS_PF_BASE_HI) |-> avs_readdata == pf_base_hi_q)
		else $error("base upper readback wrong");

	limit_hi_rd_a: assert property (rd_done_at(OFS_PF_LIMIT_HI) |-> avs_readdata == pf_limit_hi_q)
		else $error("limit upper readback wrong");

	io_hi_rd_a: assert property (rd_done_at(OFS_IO_HI) |->
		avs_readdata[15:0] == io_base_hi_q && avs_readdata[31:16] == io_limit_hi_q)
		else $error("io upper readback wrong");

	pf_low_rd_a: assert property (rd_done_at(OFS_PF_LOW) |->
		avs_readdata[15:4] == pf_base_q && avs_readdata[31:20] == pf_limit_q)
		else $error("prefetch low readback wrong");

	irq_line_rd_a: assert property (rd_done_at(OFS_IRQ) |-> avs_readdata[7:0] == irq_line_q)
		else $error("interrupt line readback wrong");

	// unmapped space must not alias onto a live register
	unmapped_rd_a: assert property (rd_done_at(8'h40) |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped offset not zero");

	io_fwd_hit_a: assert property (io_addr_valid |=>
		io_fwd_valid && io_fwd_upper_hit == ($past(io_addr[31:16]) >= $past(io_base_hi_q) &&
		$past(io_addr[31:16]) <= $past(io_limit_hi_q)))
		else $error("io forward decision wrong");

	// a stale address behind a dropped qualifier must never report a hit
	fwd_idle_a: assert property (!mem_addr_valid |=> !mem_fwd_valid && !mem_fwd_hit)
		else $error("forward flags without a request");

	io_idle_a: assert property (!io_addr_valid |=> !io_fwd_valid && !io_fwd_upper_hit)
		else $error("io flags without a request");

	// bottom above top is legal to program but must forward nothing
	sequence inverted_win_seen;
		mem_addr_valid && (pf_win.bottom > pf_win.top);
	endsequence

	inverted_win_a: assert property (inverted_win_seen |=> !mem_fwd_hit)
		else $error("inverted window reported a hit");

	// wait stays up between requests so a late master never slips through
	wait_idle_a: assert property (!req_any |=> wait_q)
		else $error("waitrequest low while idle");

	rdata_hold_a: assert property (!(req.rd && wait_q) |=> $stable(avs_readdata))
		else $error("read data moved without a read");

endmodule : bwcfg_regs

//--- bwcfg_cfg_master.sv
// configuration master model that drives the avalon-mm register port
`timescale 1ns/1ps
module bwcfg_cfg_master
	import bwcfg_pkg::*;
(
	input wire logic clk,
	output logic [BWCFG_AW-1:0] address,
	output logic read,
	output logic write,
	output logic [BWCFG_DW-1:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [BWCFG_DW-1:0] readdata,
	input wire logic waitrequest
);
	initial begin
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
	end
	// request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		byteenable <= be;
		@(posedge clk iff !waitrequest);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// released lines carry inverted junk so a stale value never passes for a live one
		address <= ~a;
		writedata <= ~d;
		byteenable <= ~be;
	endtask : xfer
endmodule : bwcfg_cfg_master

//--- bridge_window_config_regs_test.sv
// self-checking bench for the bridge window configuration registers
`timescale 1ns/1ps
module bridge_window_config_regs_test
	import bwcfg_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic mem_addr_valid = 1'b0;
	logic io_addr_valid = 1'b0;
	logic [63:0] mem_addr = 64'h0000_0000_0000_0000;
	logic [31:0] io_addr = 32'h0000_0000;
	logic mem_fwd_valid, mem_fwd_hit, io_fwd_valid, io_fwd_upper_hit;
	logic [7:0] irq_line;
	int failures = 0;
	int tests_run = 0;
	logic [31:0] sh [0:15] = '{default: 32'h0000_0000};
	logic [31:0] seed = 32'h0000_ea1c;
	logic [7:0] al [0:6] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40};

	bwcfg_regs dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr_valid(mem_addr_valid),
		.mem_addr(mem_addr), .io_addr_valid(io_addr_valid), .io_addr(io_addr), .mem_fwd_valid(mem_fwd_valid),
		.mem_fwd_hit(mem_fwd_hit), .io_fwd_valid(io_fwd_valid), .io_fwd_upper_hit(io_fwd_upper_hit),
		.irq_line(irq_line));
	bwcfg_cfg_master m (.clk(clk), .address(avs_address), .read(avs_read), .write(avs_write),
		.writedata(avs_writedata), .byteenable(avs_byteenable), .readdata(avs_readdata),
		.waitrequest(avs_waitrequest));

	initial begin
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [31:0] rd_exp(input logic [7:0] a);
		case (a)
			8'h24: rd_exp = (sh[9] & 32'hfff0_fff0) | 32'h0001_0001;
			8'h28, 8'h2c, 8'h30: rd_exp = sh[a[5:2]];
			8'h34: rd_exp = 32'h0000_00dc;
			8'h3c: rd_exp = sh[15] & 32'h0000_00ff;
			default: rd_exp = 32'h0000_0000;
		endcase
	endfunction : rd_exp

	function automatic logic [63:0] wbot();
		return {sh[10], sh[9][15:4], 20'h0_0000};
	endfunction : wbot

	function automatic logic [63:0] wtop();
		return {sh[11], sh[9][31:20], 20'hf_ffff};
	endfunction : wtop

	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word

	task automatic chk_bit(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		m.xfer(1'b1, a, d, be, q);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) sh[a[5:2]][8*i+:8] = d[8*i+:8];
		end
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		m.xfer(1'b0, a, seed, 4'hf, q);
		chk_word($sformatf("read %h", a), rd_exp(a), q);
	endtask : rd_chk

	// results land one edge after the sample, so look half a cycle later
	task automatic dec(input logic [63:0] ma, input logic [31:0] ia);
		logic io_exp;
		io_exp = ia[31:16] >= sh[12][15:0] && ia[31:16] <= sh[12][31:16];
		@(posedge clk);
		mem_addr_valid <= 1'b1;
		mem_addr <= ma;
		io_addr_valid <= 1'b1;
		io_addr <= ia;
		@(posedge clk);
		mem_addr_valid <= 1'b0;
		mem_addr <= ~ma;
		io_addr_valid <= 1'b0;
		io_addr <= ~ia;
		@(negedge clk);
		chk_bit("mem_fwd_valid", 1'b1, mem_fwd_valid);
		chk_bit("mem_fwd_hit", ma >= wbot() && ma <= wtop(), mem_fwd_hit);
		chk_bit("io_fwd_valid", 1'b1, io_fwd_valid);
		chk_bit("io_fwd_upper_hit", io_exp, io_fwd_upper_hit);
		// the dropped qualifier must clear mem_fwd_valid, mem_fwd_hit and io_fwd_upper_hit even where the stale address would hit
		@(negedge clk);
		chk_bit("mem_fwd_valid low", 1'b0, mem_fwd_valid);
		chk_bit("mem_fwd_hit low", 1'b0, mem_fwd_hit);
		chk_bit("io_fwd_upper_hit low", 1'b0, io_fwd_upper_hit);
	endtask : dec

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		foreach (al[i]) rd_chk(al[i]);
		chk_word("irq_line", 32'h0000_0000, {24'h00_0000, irq_line});
		// random offsets and lanes, read-only and unmapped places included
		repeat (40) begin
			seed = lfsr(seed);
			wr(al[seed % 7], lfsr(seed), seed[7:4]);
			seed = lfsr(lfsr(seed));
			rd_chk(al[seed % 7]);
		end
		wr(8'h3c, 32'hffff_ffff, 4'hf);
		rd_chk(8'h3c);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_word("irq_line", 32'h0000_00ff, {24'h00_0000, irq_line});
		// window edges, with inverted and split upper halves among them
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(8'h28, seed, 4'hf);
			wr(8'h2c, seed + (i == 2), 4'hf);
			seed = lfsr(seed);
			wr(8'h24, seed, 4'hf);
			seed = lfsr(seed);
			wr(8'h30, seed, 4'hf);
			dec(wbot(), {sh[12][15:0], 16'h0000});
			dec(wbot() - 1, {sh[12][15:0], 16'h0000} - 1);
			dec(wtop(), {sh[12][31:16], 16'hffff});
			dec(wtop() + 1, {sh[12][31:16], 16'hffff} + 1);
		end
		// reset again mid-run: every written field must fall back
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		sh = '{default: 32'h0000_0000};
		foreach (al[i]) rd_chk(al[i]);
		chk_word("irq_line after reset", 32'h0000_0000, {24'h00_0000, irq_line});
		print_verdict();
	end
endmodule : bridge_window_config_regs_test
